//--- rtl/pcc_map.vh
// Constants for the cascade configuration hand-off block
`ifndef PCC_MAP_VH
`define PCC_MAP_VH
`define PCC_CLK_HZ          40000000
`define PCC_LINK_PERIOD_NS  25
`define PCC_LINK_DIV        1
`define PCC_SCHEME_ACTIVE   1'b1
`define PCC_SCHEME_PASSIVE  1'b0
`define PCC_LANE_LOW        1'b0
`define PCC_LANE_HIGH       1'b1
`define PCC_BYTE_W          8
`define PCC_WORD_W          16
`define PCC_LEN_W           24
`define PCC_LEN_RST         24'h000000
`define PCC_ST_IDLE         3'h0
`define PCC_ST_LOAD         3'h1
`define PCC_ST_WAITDONE     3'h2
`define PCC_ST_INIT         3'h3
`define PCC_ST_ERROR        3'h4
`endif

//--- rtl/pcc_sync2.v
// Two flip-flop synchroniser for a level from outside the clock domain
module pcc_sync2 (
    input  wire clk_in,
    input  wire sys_rst_in,
    input  wire d_in,
    output wire q_out
);
    reg meta_r;
    reg sync_r;
    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
        end else begin
            meta_r <= d_in;
            sync_r <= meta_r;
        end
    end
    assign q_out = sync_r;
endmodule // pcc_sync2

//--- rtl/pcc_odrain.v
// Open-drain pin driver: pull low or release
module pcc_odrain (
    input  wire clk_in,
    input  wire sys_rst_in,
    input  wire pull_low_in,
    output reg  pin_out,
    output reg  pin_oe_out
);
    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pin_out    <= 1'b0;
            pin_oe_out <= 1'b1;
        end else begin
            pin_out    <= 1'b0;
            pin_oe_out <= pull_low_in;
        end
    end
endmodule // pcc_odrain

//--- rtl/pcc_top.v
// Cascade configuration loader: master clocking, slave byte capture, chain hand-off
// Operation
// [RL1] Board ties first chain-enable input low
// [RL2] Chain-enable out feeds next chain-enable in
// [RL3] Own data received: drive chain-enable low
// [RL4] Last device chain-enable becomes user pin
// [RL5] Shared request, status, done, clock, data
// [RL6] Active strap makes master driving clock
// [RL7] Other devices strapped passive as slaves
// [RL8] Byte mode slaves use low lane
// [RL9] Word mode slaves split low/high lanes
// [RL10] Master enables two slave chains together
// [RL11] Master ignores flash wait while configuring
// [RL12] Status and done driven open-drain
// [RL13] Release done with chain-enable assertion
// [RL14] Hold done low until data received
// [RL15] Enter initialization when done rises
// [RL16] Master clock from 40 MHz oscillator
// [RL17] Flash presents data on rising clock
// [RL18] Enabled slave captures byte per edge
`include "pcc_map.vh"
module pcc_top (
    input  wire                   clk_in,
    input  wire                   sys_rst_in,
    input  wire                   scheme_strap_in,
    input  wire                   lane_sel_in,
    input  wire                   word_mode_in,
    input  wire [`PCC_LEN_W-1:0]  image_len_in,
    input  wire                   chain_en_n_in,
    input  wire                   config_request_n_in,
    input  wire                   config_status_n_in,
    input  wire                   config_complete_line_in,
    input  wire                   config_clock_in,
    input  wire [`PCC_WORD_W-1:0] data_in,
    input  wire                   flash_wait_in,
    input  wire                   user_pin_in,
    output reg                    config_clock_out,
    output reg                    config_clock_oe_out,
    output reg                    chain_en_n_out,
    output wire                   config_status_n_out,
    output wire                   config_status_n_oe_out,
    output wire                   config_complete_line_out,
    output wire                   config_complete_line_oe_out,
    output reg  [`PCC_BYTE_W-1:0] cfg_byte_out,
    output reg                    cfg_byte_valid_out,
    output reg                    init_start_out,
    output reg                    user_mode_out,
    output reg                    flash_wait_user_out
);
    localparam [2:0] ST_IDLE     = `PCC_ST_IDLE;
    localparam [2:0] ST_LOAD     = `PCC_ST_LOAD;
    localparam [2:0] ST_WAITDONE = `PCC_ST_WAITDONE;
    localparam [2:0] ST_INIT     = `PCC_ST_INIT;
    localparam [2:0] ST_ERROR    = `PCC_ST_ERROR;

    // Link pin inputs pass two flip-flops; strap, lane, mode and length inputs are used directly
    wire chain_en_n_s;
    wire cfg_req_n_s;
    wire status_n_s;
    wire done_s;
    wire link_clk_s;
    wire wait_s;
    wire user_pin_s;
    wire [`PCC_WORD_W-1:0] data_s;
    pcc_sync2 u_s_ce (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .d_in       (chain_en_n_in),
        .q_out      (chain_en_n_s)
    );
    pcc_sync2 u_s_req (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .d_in       (config_request_n_in),
        .q_out      (cfg_req_n_s)
    );
    pcc_sync2 u_s_st (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .d_in       (config_status_n_in),
        .q_out      (status_n_s)
    );
    pcc_sync2 u_s_done (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .d_in       (config_complete_line_in),
        .q_out      (done_s)
    );
    pcc_sync2 u_s_clk (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .d_in       (config_clock_in),
        .q_out      (link_clk_s)
    );
    pcc_sync2 u_s_wait (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .d_in       (flash_wait_in),
        .q_out      (wait_s)
    );
    pcc_sync2 u_s_user (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .d_in       (user_pin_in),
        .q_out      (user_pin_s)
    );
    genvar gi;
    generate
        for (gi = 0; gi < `PCC_WORD_W; gi = gi + 1) begin : g_dsync
            pcc_sync2 u_s_d (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
                             .d_in(data_in[gi]), .q_out(data_s[gi]));
        end
    endgenerate

    // Lane pick shared by both roles
    function [`PCC_BYTE_W-1:0] lane_pick;
        input [`PCC_WORD_W-1:0] w;
        input                   wm;
        input                   sel;
        begin
            if (wm && (sel == `PCC_LANE_HIGH))
                lane_pick = w[15:8];
            else
                lane_pick = w[7:0];
        end
    endfunction

    reg        is_master_r;
    reg        strap_taken_r;
    reg        clk_prev_r;
    reg  [2:0] state_r;
    reg  [2:0] state_nxt;
    reg  [`PCC_LEN_W-1:0] count_r;
    reg        done_hold_r;
    reg        done_hold_nxt;
    reg        status_hold_r;
    reg        done_prev_r;
    reg        req_prev_r;
    wire       link_rise;
    wire       done_rise;
    wire       req_fall;
    wire       enabled;
    wire       last_byte;
    wire       word_step;

    // Strap caught after reset release
    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            is_master_r   <= 1'b0;
            strap_taken_r <= 1'b0;
        end else if (!strap_taken_r) begin
            is_master_r   <= (scheme_strap_in == `PCC_SCHEME_ACTIVE); // RL6
            strap_taken_r <= 1'b1;
        end
    end

    // Master drives clock from its own oscillator domain; slave samples edges
    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            config_clock_out    <= 1'b0;
            config_clock_oe_out <= 1'b0;
        end else begin
            config_clock_oe_out <= is_master_r && strap_taken_r; // RL6
            if (is_master_r && (state_r == ST_LOAD))
                config_clock_out <= ~config_clock_out; // RL16
            else
                config_clock_out <= 1'b0;
        end
    end

    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            clk_prev_r  <= 1'b0;
            done_prev_r <= 1'b0;
            req_prev_r  <= 1'b0;
        end else begin
            clk_prev_r  <= link_clk_s;
            done_prev_r <= done_s;
            req_prev_r  <= cfg_req_n_s;
        end
    end

    // Master samples on its own falling half so flash data settled after rise
    assign link_rise = is_master_r ? config_clock_out
                                   : (link_clk_s && !clk_prev_r); // RL17
    assign done_rise = done_s && !done_prev_r;
    assign req_fall  = !cfg_req_n_s && req_prev_r;
    assign enabled   = is_master_r ? 1'b1 : !chain_en_n_s; // RL1 RL18
    assign word_step = word_mode_in && is_master_r;
    assign last_byte = (count_r + 24'h000001 == image_len_in) ||
                       (word_step && (count_r + 24'h000002 == image_len_in));

    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (strap_taken_r && cfg_req_n_s && status_n_s && enabled)
                    state_nxt = ST_LOAD;
            end
            ST_LOAD: begin
                if (!status_n_s)
                    state_nxt = ST_ERROR;
                else if (link_rise && last_byte)
                    state_nxt = ST_WAITDONE;
            end
            ST_WAITDONE: begin
                if (done_rise || done_s)
                    state_nxt = ST_INIT; // RL15
            end
            ST_INIT: begin
                state_nxt = ST_INIT;
            end
            ST_ERROR: begin
                state_nxt = ST_ERROR;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        if (req_fall)
            state_nxt = ST_IDLE;
    end

    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_r <= ST_IDLE;
            count_r <= `PCC_LEN_RST;
        end else begin
            state_r <= state_nxt;
            if (state_r != ST_LOAD)
                count_r <= `PCC_LEN_RST;
            else if (link_rise)
                count_r <= count_r + (word_step ? 24'h000002 : 24'h000001);
        end
    end

    // Done release lands on the hand-off edge itself
    always @* begin
        done_hold_nxt = done_hold_r;
        if (req_fall)
            done_hold_nxt = 1'b1;
        else if ((state_r == ST_LOAD) && (state_nxt == ST_WAITDONE))
            done_hold_nxt = 1'b0; // RL13
        else if ((state_r == ST_IDLE) || (state_r == ST_LOAD))
            done_hold_nxt = 1'b1; // RL14
    end

    // Byte capture into the device, gated by chain enable in the slave role (master always enabled)
    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cfg_byte_out       <= 8'h00;
            cfg_byte_valid_out <= 1'b0;
        end else begin
            cfg_byte_valid_out <= 1'b0;
            if ((state_r == ST_LOAD) && link_rise && enabled) begin // RL18
                cfg_byte_out       <= lane_pick(data_s, word_mode_in,
                                                lane_sel_in); // RL8 RL9
                cfg_byte_valid_out <= 1'b1;
            end
        end
    end

    // Chain hand-off and done release together
    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            chain_en_n_out      <= 1'b1;
            done_hold_r         <= 1'b1;
            status_hold_r       <= 1'b1;
            init_start_out      <= 1'b0;
            user_mode_out       <= 1'b0;
            flash_wait_user_out <= 1'b0;
        end else begin
            status_hold_r  <= (state_r == ST_IDLE) && !strap_taken_r ||
                              (state_r == ST_ERROR); // RL12
            init_start_out <= (state_r == ST_WAITDONE) && (state_nxt == ST_INIT); // RL15
            if (req_fall) begin
                chain_en_n_out <= 1'b1;
                user_mode_out  <= 1'b0;
            end else if ((state_r == ST_LOAD) && (state_nxt == ST_WAITDONE)) begin
                chain_en_n_out <= 1'b0; // RL3 RL10
            end else if (state_r == ST_INIT) begin
                user_mode_out  <= 1'b1;
                chain_en_n_out <= user_mode_out ? user_pin_s : 1'b0; // RL4
            end
            done_hold_r         <= done_hold_nxt;
            // Wait ignored while loading, visible only in user mode
            flash_wait_user_out <= (state_r == ST_INIT) ? wait_s : 1'b0; // RL11
        end
    end

    pcc_odrain u_od_done (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .pull_low_in(done_hold_nxt), // RL12
        .pin_out    (config_complete_line_out),
        .pin_oe_out (config_complete_line_oe_out)
    );
    pcc_odrain u_od_status (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .pull_low_in(status_hold_r),
        .pin_out    (config_status_n_out),
        .pin_oe_out (config_status_n_oe_out)
    );
endmodule // pcc_top

//--- tb/pcc_top_monitor.sv
// Checker for the cascade loader ports, bound to the top module
module pcc_top_monitor (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic chain_en_n_out,
    input wire logic config_clock_out,
    input wire logic config_clock_oe_out,
    input wire logic config_status_n_out,
    input wire logic config_complete_line_out,
    input wire logic config_complete_line_oe_out,
    input wire logic cfg_byte_valid_out,
    input wire logic init_start_out,
    input wire logic user_mode_out,
    input wire logic flash_wait_user_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    sequence s_enter_user;
        ##1 (user_mode_out && !init_start_out);
    endsequence
    property p_hand_off; $fell(chain_en_n_out) |-> !config_complete_line_oe_out; endproperty
    a_hand_off: assert property (p_hand_off) else $error("done kept after hand-off");
    property p_hold_done;
        (chain_en_n_out && !user_mode_out && !init_start_out) |-> config_complete_line_oe_out;
    endproperty
    a_hold_done: assert property (p_hold_done) else $error("done released early");
    property p_open_drain; !config_status_n_out && !config_complete_line_out; endproperty
    a_open_drain: assert property (p_open_drain) else $error("line driven high");
    property p_wait_ign; cfg_byte_valid_out |-> !flash_wait_user_out; endproperty
    a_wait_ign: assert property (p_wait_ign) else $error("wait seen while loading");
    property p_clk_oe; config_clock_out |-> config_clock_oe_out; endproperty
    a_clk_oe: assert property (p_clk_oe) else $error("clock without enable");
    property p_clk_toggle; config_clock_out |=> !config_clock_out; endproperty
    a_clk_toggle: assert property (p_clk_toggle) else $error("clock high too long");
    property p_valid_pulse; cfg_byte_valid_out |=> !cfg_byte_valid_out; endproperty
    a_valid_pulse: assert property (p_valid_pulse) else $error("valid too long");
    property p_init_user; init_start_out |-> s_enter_user; endproperty
    a_init_user: assert property (p_init_user) else $error("no user mode after init");
    property p_init_cause; init_start_out |-> !config_complete_line_oe_out; endproperty
    a_init_cause: assert property (p_init_cause) else $error("init while holding done");
endmodule // pcc_top_monitor

bind pcc_top pcc_top_monitor i_pcc_top_monitor (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .chain_en_n_out(chain_en_n_out),
    .config_clock_out(config_clock_out), .config_clock_oe_out(config_clock_oe_out),
    .config_status_n_out(config_status_n_out),
    .config_complete_line_out(config_complete_line_out),
    .config_complete_line_oe_out(config_complete_line_oe_out),
    .cfg_byte_valid_out(cfg_byte_valid_out), .init_start_out(init_start_out),
    .user_mode_out(user_mode_out), .flash_wait_user_out(flash_wait_user_out));

//--- tb/pcc_far_model.sv
// Far side: flash data, link clock per frame, pulled-up shared lines
module pcc_far_model (
    input  wire logic        frame_in,
    input  wire logic [15:0] word_in,
    input  wire logic        done_oe_in,
    input  wire logic        status_oe_in,
    input  wire logic        hold_done_in,
    output logic             link_clk_out,
    output wire logic [15:0] data_out,
    output wire logic        done_line_out,
    output wire logic        status_line_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial link_clk_out = 1'b0;
    // One rising edge per frame, still in between
    always @(posedge frame_in) begin
        #100 link_clk_out = 1'b1;
        #100 link_clk_out = 1'b0;
    end
    // Released bus shows the inverse, not the last word
    assign data_out = frame_in ? word_in : ~word_in;
    assign done_line_out = !(done_oe_in || hold_done_in);
    assign status_line_out = !status_oe_in;
endmodule // pcc_far_model

//--- tb/pcc_top_tb.sv
// Self-checking bench for the cascade configuration loader
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fails++; \
    $display("[FAIL] %0t got %h expected %h", $time, a, b); end end
module pcc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_in = 1'b0, sys_rst_in = 1'b1, strap = 1'b0, lane = 1'b0, wm = 1'b0;
    logic [23:0] len = 24'h000001;
    logic        chain_n = 1'b1, req_n = 1'b1, fwait = 1'b0, upin = 1'b0;
    logic        frame = 1'b0, hold_done = 1'b0;
    logic [15:0] word = 16'h0000;
    wire         lclk, done_ln, stat_ln, clk_o, clk_oe, chain_o, st_oe, dn_oe;
    wire         valid, init_s, user_m, wait_u;
    wire  [15:0] data;
    wire  [7:0]  byte_o;
    int          fails = 0, check_count = 0, nvalid = 0, hi = 0;
    logic [7:0]  got = 8'h00;
    pcc_top i_pcc_top (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .scheme_strap_in(strap),
        .lane_sel_in(lane), .word_mode_in(wm), .image_len_in(len), .chain_en_n_in(chain_n),
        .config_request_n_in(req_n), .config_status_n_in(stat_ln),
        .config_complete_line_in(done_ln), .config_clock_in(lclk), .data_in(data),
        .flash_wait_in(fwait), .user_pin_in(upin), .config_clock_out(clk_o),
        .config_clock_oe_out(clk_oe), .chain_en_n_out(chain_o), .config_status_n_out(),
        .config_status_n_oe_out(st_oe), .config_complete_line_out(),
        .config_complete_line_oe_out(dn_oe), .cfg_byte_out(byte_o),
        .cfg_byte_valid_out(valid), .init_start_out(init_s), .user_mode_out(user_m),
        .flash_wait_user_out(wait_u));
    pcc_far_model i_pcc_far_model (.frame_in(frame), .word_in(word), .done_oe_in(dn_oe),
        .status_oe_in(st_oe), .hold_done_in(hold_done), .link_clk_out(lclk),
        .data_out(data), .done_line_out(done_ln), .status_line_out(stat_ln));
    initial forever #12.5 clk_in = ~clk_in;
    always @(posedge clk_in) if (valid === 1'b1) begin
        got <= byte_o;
        nvalid = nvalid + 1;
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic do_reset(input logic s, input logic w, input logic l, input logic [23:0] n);
        @(posedge clk_in);
        sys_rst_in <= 1'b1; strap <= s; wm <= w; lane <= l; len <= n; chain_n <= 1'b1;
        repeat (16) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        nvalid = 0;
        repeat (4) @(posedge clk_in);
    endtask
    task automatic send(input logic [15:0] w);
        @(posedge clk_in);
        word <= w; frame <= 1'b1;
        @(negedge lclk);
        @(posedge clk_in);
        frame <= 1'b0;
        repeat (6) @(posedge clk_in);
    endtask
    task automatic t_slave_byte();
        hold_done <= 1'b1;
        do_reset(1'b0, 1'b0, 1'b0, 24'h000002);
        `CHK(chain_o, 1'b1)
        `CHK(dn_oe, 1'b1)
        `CHK(st_oe, 1'b0)
        send(16'hA55A);
        `CHK(nvalid, 0)
        chain_n <= 1'b0;
        repeat (4) @(posedge clk_in);
        send(16'h3C12);
        `CHK(got, 8'h12)
        `CHK(chain_o, 1'b1)
        fwait <= 1'b1;
        send(16'h7E99);
        `CHK(got, 8'h99)
        `CHK(nvalid, 2)
        `CHK(chain_o, 1'b0)
        `CHK(dn_oe, 1'b0)
        `CHK(wait_u, 1'b0)
        repeat (8) @(posedge clk_in);
        `CHK(user_m, 1'b0)
        hold_done <= 1'b0;
        repeat (8) @(posedge clk_in);
        `CHK(user_m, 1'b1)
        `CHK(wait_u, 1'b1)
        upin <= 1'b1;
        repeat (4) @(posedge clk_in);
        `CHK(chain_o, 1'b1)
        $display("slave byte test done");
    endtask
    task automatic t_slave_word();
        upin <= 1'b0;
        do_reset(1'b0, 1'b1, 1'b1, 24'h000001);
        chain_n <= 1'b0;
        repeat (4) @(posedge clk_in);
        send(16'hC3A7);
        `CHK(got, 8'hC3)
        `CHK(chain_o, 1'b0)
        $display("slave word test done");
    endtask
    task automatic t_master();
        fwait <= 1'b1;
        do_reset(1'b1, 1'b1, 1'b0, 24'h000004);
        chain_n <= 1'b0;
        hi = 0;
        for (int i = 0; i < 60 && chain_o !== 1'b0; i++) begin
            @(negedge clk_in);
            if (clk_o === 1'b1) hi++;
            if (clk_o === 1'b1) `CHK(wait_u, 1'b0)
        end
        repeat (2) @(posedge clk_in);
        `CHK(chain_o, 1'b0)
        `CHK(hi, 2)
        `CHK(clk_oe, 1'b1)
        `CHK(nvalid, 2)
        req_n <= 1'b0;
        repeat (4) @(posedge clk_in);
        `CHK(chain_o, 1'b1)
        `CHK(dn_oe, 1'b1)
        req_n <= 1'b1;
        $display("master test done");
    endtask
    initial begin
        #200us;
        fails++;
        $display("[FAIL] %0t watchdog expired", $time);
        summarize();
    end
    initial begin
        t_slave_byte();
        t_slave_word();
        t_master();
        summarize();
    end
endmodule // pcc_top_tb
